// ---- core/ocf_pkg.sv ----
// Purpose: shared constants and carriers for the output clock and
//          frame sync control block
// Assumes: 20 MHz system clock
// Notes:   nominal frequencies are reporting values, in kHz
package ocf_pkg;
    // ----------------------------------------------------------------
    // clocking and timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int FRAME_KHZ = 8;
    localparam int MFRAME_KHZ = 2;
    localparam int FRAME_CYC = CLK_KHZ / FRAME_KHZ;
    localparam int MFRAME_CYC = CLK_KHZ / MFRAME_KHZ;
    localparam int PPS_CYC = CLK_KHZ * 1000;
    // one unit of the sync offset limit, least time, rounded up
    localparam int SYNC_STEP_NS = 50;
    localparam int SYNC_STEP_CYC = (SYNC_STEP_NS * CLK_KHZ + 999999)
                                   / 1000000;
    localparam int N_OUT = 12;
    localparam int N_PH_OUT = 7;
    localparam int N_IN = 12;
    localparam int LOOP_PH_W = 29;
    localparam int IN_PH_W = 8;
    localparam int FINE_W = 4;
    localparam int COARSE_W = 8;
    // ----------------------------------------------------------------
    // nominal output frequencies after reset
    // ----------------------------------------------------------------
    localparam logic [31:0] OUT1_KHZ = 32'h0000_61a8;  // 25 MHz
    localparam logic [31:0] OUT2_KHZ = 32'h0001_e848;  // 125 MHz
    localparam logic [31:0] OUT3_KHZ = 32'h0002_625a;  // 156.25 MHz
    localparam logic [31:0] OUT9_KHZ = 32'h0000_4000;  // 16.384 MHz
    localparam logic [31:0] OUT10_KHZ = 32'h0000_0800; // 2.048 MHz
    // ----------------------------------------------------------------
    // hold codes
    // ----------------------------------------------------------------
    localparam logic [1:0] HOLD_LOW = 2'h2;
    localparam logic [1:0] HOLD_HIGH = 2'h3;
    localparam logic [1:0] HOLD_NONE = 2'h0;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [9:0] output_polarity_flip;      // outputs 1..10
        logic [9:0][1:0] output_hold_code;     // outputs 1..10
        logic [6:0] output_power_off;          // outputs 1..7
        logic composite_output_power_off;      // output 8
        logic rate_loop_input_fail_gate;
        logic low_jitter_out_a_on;             // output 11
        logic low_jitter_out_b_on;             // output 12
        logic digital_loop_three_on;
    } ocf_out_cfg_t;
    localparam ocf_out_cfg_t OUT_CFG_RESET = '{
        output_polarity_flip: 10'h000,
        // outputs 4..7 (entries 3..6) carry code 10, the rest pass
        output_hold_code: {6'h00, 8'haa, 6'h00},
        output_power_off: 7'h00,
        composite_output_power_off: 1'b1,
        rate_loop_input_fail_gate: 1'b0,
        low_jitter_out_a_on: 1'b0,
        low_jitter_out_b_on: 1'b0,
        digital_loop_three_on: 1'b0
    };
    typedef struct packed {
        logic frame_pulse_on;
        logic multiframe_pulse_on;
        logic frame_pulse_flip;
        logic multiframe_pulse_flip;
        logic frame_pulse_narrow;
        logic multiframe_pulse_narrow;
        logic narrow_pulse_placement;  // 1: rising edge position
        logic pps_mode;                // 1: both pins carry 1 pps
        logic sync_edge_rise;          // 1: align the rising edge
        logic [2:0] sync_offset_limit;
        logic auto_resync_allow;
        logic manual_resync_allow;
    } ocf_sync_cfg_t;
endpackage

// ---- core/ocf_output_control.sv ----
// Purpose: output gating, frame sync generation, sync monitor and
//          phase offset selection
// Assumes: loop clocks arrive already on the system clock domain
// Notes:   pins from outside pass a three flop filter
`timescale 1ns/1ps
module ocf_output_control #(
    parameter int MFRAME_CYCLES = ocf_pkg::MFRAME_CYC,
    parameter int PPS_CYCLES = ocf_pkg::PPS_CYC
) (
    input wire logic i_clk,                       // system clock
    input wire logic i_reset,                     // sync, active high
    input wire logic i_cfg_load,                  // take i_out_cfg
    input wire ocf_pkg::ocf_out_cfg_t i_out_cfg,  // output config
    input wire ocf_pkg::ocf_sync_cfg_t i_sync_cfg, // sync config
    input wire logic [11:0] i_loop_clk,           // raw output clocks
    input wire logic i_loop3_input_fail,          // loop three input
    input wire logic i_sync_pin,                  // external sync pin
    input wire logic i_ref_pin,                   // reference pin
    input wire logic i_alarm_clear,               // clear latched alarm
    input wire logic i_standby_unit,              // inactive redundant
    input wire logic i_loop_phase_shift_on,       // loop offset enable
    input wire logic i_manual_phase,              // manual, drops in offset
    input wire logic [28:0] i_loop_phase_shift_value, // loop offset
    input wire logic [11:0][7:0] i_input_phase_shift_value, // inputs
    input wire logic [3:0] i_selected_input,      // 0..11 = in 3..14
    input wire logic [6:0] i_analog_src,          // out 1..7 analog fed
    input wire logic [6:0][3:0] i_output_fine_shift, // fine steps
    input wire logic [6:0][7:0] i_output_coarse_shift_a, // div1 steps
    input wire logic [6:0][7:0] i_output_coarse_shift_b, // div2 steps
    output logic [11:0] o_out,                    // output clocks
    output logic o_frame_pulse_pin,               // 8 kHz / 1 pps
    output logic o_multiframe_pulse_pin,          // 2 kHz / 1 pps
    output logic o_sync_alarm_live,               // alarm now
    output logic o_sync_alarm_latched,            // sticky alarm
    output logic o_sync_irq,                      // interrupt level
    output logic o_loop_one_run,                  // first analog loop
    output logic o_digital_loop_three_run,        // third loop enabled
    output logic [4:0][31:0] o_nominal_khz,       // out 1,2,3,9,10
    output logic [28:0] o_loop_phase,             // applied loop offset
    output logic [7:0] o_input_phase,             // applied in offset
    output logic [6:0][3:0] o_fine_applied,       // applied fine shift
    output logic [6:0][7:0] o_coarse_a,           // applied coarse a
    output logic [6:0][7:0] o_coarse_b            // applied coarse b
);
    import ocf_pkg::*;

    // the frame counters are 25 bits wide
    if (MFRAME_CYCLES < 4 || PPS_CYCLES < MFRAME_CYCLES ||
        PPS_CYCLES > 33554432) begin : g_bad
        $error("ocf_output_control: bad frame counts");
    end

    // ----------------------------------------------------------------
    // configuration
    // ----------------------------------------------------------------
    ocf_out_cfg_t cfg;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cfg <= OUT_CFG_RESET;
        end else if (i_cfg_load) begin
            cfg <= i_out_cfg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_loop_one_run <= 1'b0;
            o_digital_loop_three_run <= 1'b0;
            o_nominal_khz <= '0;
        end else begin
            o_loop_one_run <= 1'b1;
            o_digital_loop_three_run <= cfg.digital_loop_three_on;
            o_nominal_khz <= {OUT10_KHZ, OUT9_KHZ, OUT3_KHZ, OUT2_KHZ,
                              OUT1_KHZ};
        end
    end

    // ----------------------------------------------------------------
    // output gating
    // ----------------------------------------------------------------
    logic [11:0] out_on;
    always_comb begin
        out_on = '1;
        out_on[6:0] = ~cfg.output_power_off;
        out_on[7] = ~cfg.composite_output_power_off &
                    ~(cfg.rate_loop_input_fail_gate & i_loop3_input_fail);
        out_on[8] = cfg.digital_loop_three_on;
        out_on[9] = cfg.digital_loop_three_on;
        out_on[10] = cfg.low_jitter_out_a_on;
        out_on[11] = cfg.low_jitter_out_b_on;
    end

    for (genvar i = 0; i < N_OUT; i++) begin : g_out
        logic level;
        if (i < 10) begin : g_ctl
            always_comb begin
                unique case (cfg.output_hold_code[i])
                    HOLD_LOW: level = 1'b0;
                    HOLD_HIGH: level = 1'b1;
                    default: level = i_loop_clk[i] ^
                                     cfg.output_polarity_flip[i];
                endcase
            end
        end else begin : g_plain
            assign level = i_loop_clk[i];
        end
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                o_out[i] <= 1'b0;
            end else begin
                o_out[i] <= out_on[i] & level;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin filters: three flops, a change counts when 2nd and 3rd agree
    // ----------------------------------------------------------------
    logic [1:0] pin_in;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic [1:0] pin_f;
    logic [1:0] pin_fd;
    assign pin_in = {i_ref_pin, i_sync_pin};
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_f <= '0;
            pin_fd <= '0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
            pin_fd <= pin_f;
        end
    end

    logic sync_edge;
    logic ref_rise;
    assign sync_edge = i_sync_cfg.sync_edge_rise ?
                       (pin_f[0] & ~pin_fd[0]) :
                       (~pin_f[0] & pin_fd[0]);
    assign ref_rise = pin_f[1] & ~pin_fd[1];

    // ----------------------------------------------------------------
    // frame counters
    // ----------------------------------------------------------------
    logic [24:0] fr_cnt;
    logic [24:0] mf_cnt;
    logic [24:0] pps_cnt;
    logic armed;
    logic align;
    assign align = armed & ref_rise;
    always_ff @(posedge i_clk) begin
        if (i_reset || align) begin
            fr_cnt <= '0;
            mf_cnt <= '0;
            pps_cnt <= '0;
        end else begin
            fr_cnt <= (fr_cnt == 25'(FRAME_CYC - 1)) ? '0 : fr_cnt + 1'b1;
            mf_cnt <= (mf_cnt == 25'(MFRAME_CYCLES - 1)) ? '0 :
                      mf_cnt + 1'b1;
            pps_cnt <= (pps_cnt == 25'(PPS_CYCLES - 1)) ? '0 :
                       pps_cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // sync monitor
    // ----------------------------------------------------------------
    logic [24:0] offset;
    logic over_limit;
    logic resync_ok;
    always_comb begin
        offset = (fr_cnt < 25'(FRAME_CYC / 2)) ? fr_cnt :
                 25'(FRAME_CYC) - fr_cnt;
        over_limit = offset > 25'(i_sync_cfg.sync_offset_limit *
                                  SYNC_STEP_CYC);
        resync_ok = i_sync_cfg.auto_resync_allow |
                    i_sync_cfg.manual_resync_allow;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sync_alarm_live <= 1'b0;
        end else if (sync_edge) begin
            o_sync_alarm_live <= over_limit;
        end
    end

    // an alarm while armed cancels the pending alignment
    always_ff @(posedge i_clk) begin
        if (i_reset || align) begin
            armed <= 1'b0;
        end else if (sync_edge) begin
            armed <= ~over_limit & resync_ok;
        end
    end

    // set wins over clear so no alarm is lost
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sync_alarm_latched <= 1'b0;
        end else if (sync_edge && over_limit) begin
            o_sync_alarm_latched <= 1'b1;
        end else if (i_alarm_clear) begin
            o_sync_alarm_latched <= 1'b0;
        end
    end
    assign o_sync_irq = o_sync_alarm_latched;

    // ----------------------------------------------------------------
    // frame pulse shaping
    // ----------------------------------------------------------------
    logic fr_wave;
    logic mf_wave;
    logic fr_nar;
    logic mf_nar;
    logic fr_lvl;
    logic mf_lvl;
    logic pps_lvl;
    always_comb begin
        fr_wave = fr_cnt < 25'(FRAME_CYC / 2);
        mf_wave = mf_cnt < 25'(MFRAME_CYCLES / 2);
        // narrow pulse lasts one internal clock period
        fr_nar = i_sync_cfg.narrow_pulse_placement ? (fr_cnt == '0) :
                 (fr_cnt == 25'(FRAME_CYC / 2));
        mf_nar = i_sync_cfg.narrow_pulse_placement ? (mf_cnt == '0) :
                 (mf_cnt == 25'(MFRAME_CYCLES / 2));
        pps_lvl = pps_cnt == '0;
        fr_lvl = i_sync_cfg.pps_mode ? pps_lvl :
                 (i_sync_cfg.frame_pulse_narrow ? fr_nar : fr_wave);
        mf_lvl = i_sync_cfg.pps_mode ? pps_lvl :
                 (i_sync_cfg.multiframe_pulse_narrow ? mf_nar :
                  mf_wave);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_frame_pulse_pin <= 1'b0;
            o_multiframe_pulse_pin <= 1'b0;
        end else begin
            o_frame_pulse_pin <= i_sync_cfg.frame_pulse_on &
                (fr_lvl ^ i_sync_cfg.frame_pulse_flip);
            o_multiframe_pulse_pin <= i_sync_cfg.multiframe_pulse_on &
                (mf_lvl ^ i_sync_cfg.multiframe_pulse_flip);
        end
    end

    // ----------------------------------------------------------------
    // phase offsets; only outputs 1..7 carry adjustment
    // ----------------------------------------------------------------
    logic loop_ph_en;
    logic in_valid;
    assign loop_ph_en = i_standby_unit | i_loop_phase_shift_on;
    assign in_valid = i_selected_input < 4'(N_IN);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_loop_phase <= '0;
            o_input_phase <= '0;
            o_fine_applied <= '0;
            o_coarse_a <= '0;
            o_coarse_b <= '0;
        end else begin
            o_loop_phase <= loop_ph_en ? i_loop_phase_shift_value :
                            '0;
            o_input_phase <= (in_valid && !i_manual_phase) ?
                i_input_phase_shift_value[i_selected_input] : '0;
            for (int k = 0; k < N_PH_OUT; k++) begin
                o_fine_applied[k] <= i_analog_src[k] ?
                    i_output_fine_shift[k] : '0;
            end
            o_coarse_a <= i_output_coarse_shift_a;
            o_coarse_b <= i_output_coarse_shift_b;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_armed_ref;
        armed ##0 ref_rise;
    endsequence
    sequence s_aligned;
        ##1 fr_cnt == '0 ##1 fr_cnt == 25'h1;
    endsequence

    chk_align_ref: assert property (s_armed_ref |-> s_aligned)
        else $error("frame counter not aligned to reference edge");
    chk_alarm_blocks: assert property (
        sync_edge && over_limit |=> !armed && o_sync_alarm_live)
        else $error("alarm did not stop resync");
    chk_alarm_sticky: assert property (
        sync_edge && over_limit |=> o_sync_irq)
        else $error("alarm not latched to interrupt");
    chk_hold_low: assert property (
        cfg.output_hold_code[4] == HOLD_LOW && out_on[4]
        |=> !o_out[4])
        else $error("held output not low");
    chk_power_off: assert property (
        cfg.output_power_off[0] |=> !o_out[0])
        else $error("powered off output toggles");
    chk_out11_off: assert property (
        !cfg.low_jitter_out_a_on |=> !o_out[10])
        else $error("output 11 active while disabled");
    chk_reset_cfg: assert property (
        $fell(i_reset) |-> cfg.composite_output_power_off &&
        cfg.output_hold_code[6] == HOLD_LOW &&
        !cfg.digital_loop_three_on)
        else $error("reset defaults wrong");
    chk_frame_off: assert property (
        !i_sync_cfg.frame_pulse_on [*2] |-> !o_frame_pulse_pin)
        else $error("frame pin active while disabled");
    chk_loop_gate: assert property (
        !i_standby_unit && !i_loop_phase_shift_on |=> o_loop_phase == '0)
        else $error("loop offset applied while disabled");
    chk_fine_gate: assert property (
        !i_analog_src[0] |=> o_fine_applied[0] == '0)
        else $error("fine shift on digital source");
endmodule

// ---- test/ocf_sync_src.sv ----
// Purpose: far side model driving the sync and reference pins
// Assumes: pins are push-pull, so a held level is a true level
// Notes:   edges are held long enough to pass the three flop filter
`timescale 1ns/1ps
module ocf_sync_src (
    input wire logic i_clk, // system clock
    output logic o_sync,    // external sync pin
    output logic o_ref      // reference clock pin
);
    initial begin
        o_sync = 1'b1;
        o_ref = 1'b0;
    end
    // one edge of either sense; the block picks which one counts
    task automatic sync_to(input logic lvl);
        @(negedge i_clk);
        o_sync = lvl;
        repeat (8) @(negedge i_clk);
    endtask
    // a single reference rise, the alignment event after a sync edge
    task automatic ref_rise();
        @(negedge i_clk);
        o_ref = 1'b1;
        repeat (8) @(negedge i_clk);
        o_ref = 1'b0;
    endtask
endmodule

// ---- test/testbench.sv ----
// Purpose: directed test of output gating, sync pins and phase paths
// Assumes: short multiframe and pps periods of 100 and 2500 cycles
// Notes:   loop clocks are static levels so gating reads directly
`timescale 1ns/1ps
module testbench;
    import ocf_pkg::*;
    logic clk, rst, load, fail, aclr, stby, lon, man, sync_w, ref_w;
    ocf_out_cfg_t ocfg, c;
    ocf_sync_cfg_t scfg;
    logic [11:0] lclk, out;
    logic [28:0] lval, lph;
    logic [11:0][7:0] ival;
    logic [3:0] sel;
    logic [6:0] asrc;
    logic [6:0][3:0] fine, fa;
    logic [6:0][7:0] ca, cb, oca, ocb;
    logic fp, mp, alive, alat, irq, l1, l3;
    logic [4:0][31:0] nom;
    logic [7:0] iph;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int hf, hm, r, r1, r0;
    ocf_output_control #(.MFRAME_CYCLES(100), .PPS_CYCLES(2500))
        ocf_output_control_i (.i_clk(clk), .i_reset(rst),
        .i_cfg_load(load), .i_out_cfg(ocfg), .i_sync_cfg(scfg),
        .i_loop_clk(lclk), .i_loop3_input_fail(fail),
        .i_sync_pin(sync_w), .i_ref_pin(ref_w), .i_alarm_clear(aclr),
        .i_standby_unit(stby), .i_loop_phase_shift_on(lon),
        .i_manual_phase(man), .i_loop_phase_shift_value(lval),
        .i_input_phase_shift_value(ival), .i_selected_input(sel),
        .i_analog_src(asrc), .i_output_fine_shift(fine),
        .i_output_coarse_shift_a(ca), .i_output_coarse_shift_b(cb),
        .o_out(out), .o_frame_pulse_pin(fp), .o_multiframe_pulse_pin(mp),
        .o_sync_alarm_live(alive), .o_sync_alarm_latched(alat),
        .o_sync_irq(irq), .o_loop_one_run(l1),
        .o_digital_loop_three_run(l3), .o_nominal_khz(nom),
        .o_loop_phase(lph), .o_input_phase(iph), .o_fine_applied(fa),
        .o_coarse_a(oca), .o_coarse_b(ocb));
    ocf_sync_src ocf_sync_src_i (.i_clk(clk), .o_sync(sync_w),
        .o_ref(ref_w));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // wide enough for the whole nominal table and both coarse arrays
    task automatic check(input string what, input logic [159:0] seen,
                         input logic [159:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic load_cfg(input ocf_out_cfg_t v);
        @(negedge clk);
        ocfg = v;
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic count_hi(output int f, output int m, output int rm);
        logic p;
        f = 0;
        m = 0;
        rm = -1;
        repeat (3) @(negedge clk);
        p = mp;
        repeat (2500) begin
            @(negedge clk);
            f += (fp === 1'b1);
            m += (mp === 1'b1);
            if (rm < 0 && mp === 1'b1 && p === 1'b0) rm = cyc;
            p = mp;
        end
    endtask
    task automatic wait_fp();
        logic p;
        p = fp;
        for (int k = 0; k < 3000; k++) begin
            @(negedge clk);
            if (fp === 1'b1 && p === 1'b0) break;
            p = fp;
        end
    endtask
    task automatic sync_at(input int ofs, input logic lvl);
        wait_fp();
        repeat (ofs) @(negedge clk);
        ocf_sync_src_i.sync_to(lvl);
    endtask
    task automatic ref_trial(output int d);
        wait_fp();
        r0 = cyc;
        // fire in the low half, so a realigned frame shows a fresh rise
        repeat (1500) @(negedge clk);
        fork
            ocf_sync_src_i.ref_rise();
        join_none
        wait_fp();
        d = cyc - r0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    initial begin
        // hang guard sized well above the longest sequence
        #(100000 * 50);
        fail_count++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; load = 1'b0; fail = 1'b0; aclr = 1'b0;
        stby = 1'b0; lon = 1'b0; man = 1'b0; ocfg = OUT_CFG_RESET;
        scfg = '0; lclk = 12'hfff; lval = 29'h1000_0001; ival = '0;
        ival[2] = 8'h85; sel = 4'h2; asrc = 7'h05; fine = 28'h9999999;
        ca = 56'h0102030405060a; cb = 56'ha0b0c0d0e0f011;
        settle(2);
        rst = 1'b0;
        settle(3);
        check("out reset", out, 12'h007);
        check("loop one", l1, 1'b1);
        check("loop three", l3, 1'b0);
        check("nominal", nom, {OUT10_KHZ, OUT9_KHZ, OUT3_KHZ,
            OUT2_KHZ, OUT1_KHZ});
        $display("test reset defaults done");
        c = OUT_CFG_RESET;
        c.output_hold_code = '0;
        c.digital_loop_three_on = 1'b1;
        c.composite_output_power_off = 1'b0;
        c.low_jitter_out_a_on = 1'b1;
        c.low_jitter_out_b_on = 1'b1;
        lclk = 12'h000;
        c.output_polarity_flip = 10'h3ff;
        load_cfg(c);
        check("flip", out, 12'h3ff);
        check("loop three on", l3, 1'b1);
        c.output_hold_code[0] = HOLD_LOW;
        c.output_hold_code[1] = HOLD_HIGH;
        c.output_hold_code[2] = 2'h1;
        load_cfg(c);
        check("hold codes", out, 12'h3fe);
        lclk = 12'hfff;
        c.output_polarity_flip = '0;
        c.output_hold_code = '0;
        c.output_power_off = 7'h55;
        load_cfg(c);
        check("power off", out, 12'hfaa);
        c.output_power_off = '0;
        c.composite_output_power_off = 1'b1;
        c.low_jitter_out_b_on = 1'b0;
        c.digital_loop_three_on = 1'b0;
        load_cfg(c);
        check("enables", out, 12'h47f);
        $display("test output gating done");
        settle(2);
        check("loop off", lph, 29'h0);
        lon = 1'b1;
        settle(2);
        check("loop on", lph, 29'h1000_0001);
        lon = 1'b0;
        stby = 1'b1;
        settle(2);
        check("standby", lph, 29'h1000_0001);
        check("input sel", iph, 8'h85);
        check("fine", fa, 28'h0000909);
        check("coarse", {oca, ocb}, {ca, cb});
        sel = 4'hc;
        settle(2);
        check("input none", iph, 8'h00);
        sel = 4'h2;
        man = 1'b1;
        settle(2);
        check("input manual", iph, 8'h00);
        $display("test phase paths done");
        // pulse pins stay low while frame_pulse_on and multiframe_pulse_on are clear
        count_hi(hf, hm, r);
        check("pins off", {hf[15:0], hm[15:0]}, 32'h0);
        scfg.frame_pulse_on = 1'b1;
        scfg.multiframe_pulse_on = 1'b1;
        count_hi(hf, hm, r0);
        check("half", {hf[15:0], hm[15:0]}, {16'd1250, 16'd1250});
        scfg.frame_pulse_narrow = 1'b1;
        scfg.multiframe_pulse_narrow = 1'b1;
        scfg.narrow_pulse_placement = 1'b1;
        count_hi(hf, hm, r1);
        check("narrow", {hf[15:0], hm[15:0]}, {16'd1, 16'd25});
        check("place rise", (r1 - r0) % 100, 0);
        scfg.narrow_pulse_placement = 1'b0;
        scfg.frame_pulse_flip = 1'b1;
        scfg.multiframe_pulse_flip = 1'b1;
        count_hi(hf, hm, r);
        check("flip", {hf[15:0], hm[15:0]}, {16'd2499, 16'd2475});
        scfg.frame_pulse_flip = 1'b0;
        scfg.multiframe_pulse_flip = 1'b0;
        count_hi(hf, hm, r1);
        check("place fall", (r1 - r0) % 100, 50);
        scfg.pps_mode = 1'b1;
        count_hi(hf, hm, r);
        check("pps", {hf[15:0], hm[15:0]}, {16'd1, 16'd1});
        $display("test pulse pins done");
        scfg = '0;
        scfg.frame_pulse_on = 1'b1;
        scfg.sync_offset_limit = 3'h7;
        scfg.auto_resync_allow = 1'b1;
        sync_at(400, 1'b0);
        check("alarm", {alive, alat, irq}, 3'h7);
        sync_at(2494, 1'b1);
        check("rise ignored", alive, 1'b1);
        sync_at(2494, 1'b0);
        check("in limit", {alive, alat}, 2'h1);
        @(negedge clk);
        aclr = 1'b1;
        @(negedge clk);
        aclr = 1'b0;
        @(negedge clk);
        check("cleared", {alat, irq}, 2'h0);
        scfg.sync_edge_rise = 1'b1;
        sync_at(2494, 1'b1);
        sync_at(400, 1'b0);
        check("fall ignored", alive, 1'b0);
        sync_at(400, 1'b1);
        check("rise alarm", alive, 1'b1);
        ref_trial(r);
        check("no resync", r, 2500);
        sync_at(400, 1'b0);
        sync_at(2494, 1'b1);
        check("back in", alive, 1'b0);
        ref_trial(r);
        check("align", r >= 1503 && r <= 1510, 1'b1);
        $display("test sync monitor done");
        end_of_test();
    end
endmodule
